// file: rtl/ptd_time_clock.v
// one time-of-day counter holding both the 96-bit and the 64-bit format
// assumes the period reset and the load strobes are synchronous to i_sys_clk
`timescale 1ns/10ps
`include "ptd_defines.vh"

module ptd_time_clock (
  input  wire                      i_sys_clk,
  input  wire                      i_rst_b,
  input  wire                      i_period_rst_b,
  input  wire                      i_load_wide,
  input  wire [`PTD_WIDE_W-1:0]    i_wide_value,
  input  wire                      i_load_narrow,
  input  wire [`PTD_NARROW_W-1:0]  i_narrow_value,
  output reg  [`PTD_WIDE_W-1:0]    o_wide_time_value,
  output reg  [`PTD_NARROW_W-1:0]  o_narrow_time_value
);

  reg  [`PTD_FRAC_W:0]   frac_sum;
  reg  [`PTD_NS_W:0]     ns_sum;
  reg  [`PTD_SEC_W-1:0]  sec_next;
  reg  [`PTD_NS_W-1:0]   ns_next;
  reg  [`PTD_FRAC_W:0]   nfrac_sum;
  reg  [`PTD_NNS_W-1:0]  nns_next;

  // the nanosecond field wraps at one second into the seconds field
  always @* begin
    frac_sum  = {1'b0, o_wide_time_value[`PTD_FRAC_MSB:0]} + {1'b0, `PTD_STEP_FRAC};
    ns_sum    = {1'b0, o_wide_time_value[`PTD_NS_MSB:`PTD_NS_LSB]} + {1'b0, `PTD_STEP_NS}
                + {{`PTD_NS_W{1'b0}}, frac_sum[`PTD_FRAC_W]};
    sec_next  = o_wide_time_value[`PTD_SEC_MSB:`PTD_SEC_LSB];
    ns_next   = ns_sum[`PTD_NS_W-1:0];
    if (ns_sum >= {1'b0, `PTD_NS_PER_SEC}) begin
      ns_next  = ns_sum[`PTD_NS_W-1:0] - `PTD_NS_PER_SEC;
      sec_next = sec_next + {{(`PTD_SEC_W-1){1'b0}}, 1'b1};
    end
    nfrac_sum = {1'b0, o_narrow_time_value[`PTD_FRAC_MSB:0]} + {1'b0, `PTD_STEP_FRAC};
    nns_next  = o_narrow_time_value[`PTD_NNS_MSB:`PTD_NNS_LSB]
                + {{(`PTD_NNS_W-`PTD_NS_W){1'b0}}, `PTD_STEP_NS}
                + {{(`PTD_NNS_W-1){1'b0}}, nfrac_sum[`PTD_FRAC_W]};
  end

  // a fresh value every cycle; period reset holds the count at zero
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wide_time_value   <= {`PTD_WIDE_W{1'b0}};
      o_narrow_time_value <= {`PTD_NARROW_W{1'b0}};
    end else if (!i_period_rst_b) begin
      o_wide_time_value   <= {`PTD_WIDE_W{1'b0}};
      o_narrow_time_value <= {`PTD_NARROW_W{1'b0}};
    end else begin
      if (i_load_wide)
        o_wide_time_value <= i_wide_value;
      else
        o_wide_time_value <= {sec_next, ns_next, frac_sum[`PTD_FRAC_W-1:0]};
      if (i_load_narrow)
        o_narrow_time_value <= i_narrow_value;
      else
        o_narrow_time_value <= {nns_next, nfrac_sum[`PTD_FRAC_W-1:0]};
    end
  end

endmodule

// file: rtl/ptd_tod_supply.v
// time-of-day supply: master, transmit and receive time clocks with format synchronizers
// assumes i_sys_clk is the mac transmit clock output and that all inputs are synchronous to it;
// the mac receive clock arrives as a plain level sampled on i_sys_clk
`timescale 1ns/10ps
`include "ptd_defines.vh"

module ptd_tod_supply (
  input  wire                      i_sys_clk,
  input  wire                      i_rst_b,
  input  wire                      i_tx_rst_b,
  input  wire                      i_rx_rst_b,
  input  wire                      i_rx_mac_clk,
  input  wire                      i_wide_en,
  input  wire                      i_narrow_en,
  input  wire                      i_shared_master,
  input  wire                      i_set_time,
  input  wire [`PTD_WIDE_W-1:0]    i_set_wide_value,
  input  wire [`PTD_NARROW_W-1:0]  i_set_narrow_value,
  output reg  [`PTD_WIDE_W-1:0]    o_transmit_wide_time_in,
  output reg  [`PTD_NARROW_W-1:0]  o_transmit_narrow_time_in,
  output reg  [`PTD_WIDE_W-1:0]    o_receive_wide_time_in,
  output reg  [`PTD_NARROW_W-1:0]  o_receive_narrow_time_in,
  output reg                       o_rx_aligned
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_WAIT  = 2'b01;
  localparam [1:0] ST_ALIGN = 2'b10;

  wire [`PTD_WIDE_W-1:0]   mst_wide;
  wire [`PTD_NARROW_W-1:0] mst_narrow;
  wire [`PTD_WIDE_W-1:0]   txs_wide;
  wire [`PTD_NARROW_W-1:0] txs_narrow;
  wire [`PTD_WIDE_W-1:0]   rxs_wide;
  wire [`PTD_NARROW_W-1:0] rxs_narrow;

  reg  [1:0]                   state_reg;
  reg  [1:0]                   state_next;
  reg  [`PTD_SYNC_CNT_W-1:0]   sync_cnt_reg;
  reg  [`PTD_SYNC_CNT_W-1:0]   sync_cnt_next;
  reg                          rx_clk_d_reg;
  reg                          mode_reg;
  wire                         rx_edge;
  wire                         sync_pulse;
  wire                         rx_load_wide;
  wire                         rx_load_narrow;
  wire                         tx_load_wide;
  wire                         tx_load_narrow;
  wire [`PTD_WIDE_W-1:0]       tx_wide_src;
  wire [`PTD_NARROW_W-1:0]     tx_narrow_src;

  wire [`PTD_WIDE_W-1:0]       slave_wide_src;
  wire [`PTD_NARROW_W-1:0]     slave_narrow_src;
  // master value one step ahead, used only for alignment loads
  wire [`PTD_WIDE_W-1:0]       mst_wide_ahead;
  wire [`PTD_NARROW_W-1:0]     mst_narrow_ahead;
  reg  [`PTD_FRAC_W:0]         ahead_frac_sum;
  reg  [`PTD_NS_W:0]           ahead_ns_sum;
  reg  [`PTD_SEC_W-1:0]        ahead_sec;
  reg  [`PTD_NS_W-1:0]         ahead_ns;
  reg  [`PTD_FRAC_W:0]         ahead_nfrac_sum;
  reg  [`PTD_NNS_W-1:0]        ahead_nns;

  // receive clock edges are seen as a one-cycle enable, never as a clock
  assign rx_edge = i_rx_mac_clk & ~rx_clk_d_reg;

  // master sits on the transmit clock and its period reset on the transmit reset
  ptd_time_clock u_master (
    .i_sys_clk           (i_sys_clk),
    .i_rst_b             (i_rst_b),
    .i_period_rst_b      (i_tx_rst_b),
    .i_load_wide         (i_set_time),
    .i_wide_value        (i_set_wide_value),
    .i_load_narrow       (i_set_time),
    .i_narrow_value      (i_set_narrow_value),
    .o_wide_time_value   (mst_wide),
    .o_narrow_time_value (mst_narrow)
  );

  // slaves load the value the master takes at this same edge; loading its present value
  // would leave every slave one step behind after each alignment
  always @* begin
    ahead_frac_sum = {1'b0, mst_wide[`PTD_FRAC_MSB:0]} + {1'b0, `PTD_STEP_FRAC};
    ahead_ns_sum   = {1'b0, mst_wide[`PTD_NS_MSB:`PTD_NS_LSB]} + {1'b0, `PTD_STEP_NS}
                     + {{`PTD_NS_W{1'b0}}, ahead_frac_sum[`PTD_FRAC_W]};
    ahead_sec      = mst_wide[`PTD_SEC_MSB:`PTD_SEC_LSB];
    ahead_ns       = ahead_ns_sum[`PTD_NS_W-1:0];
    if (ahead_ns_sum >= {1'b0, `PTD_NS_PER_SEC}) begin
      ahead_ns  = ahead_ns_sum[`PTD_NS_W-1:0] - `PTD_NS_PER_SEC;
      ahead_sec = ahead_sec + {{(`PTD_SEC_W-1){1'b0}}, 1'b1};
    end
  end

  // the 64-bit count has no one-second wrap, so it needs no seconds carry
  always @* begin
    ahead_nfrac_sum = {1'b0, mst_narrow[`PTD_FRAC_MSB:0]} + {1'b0, `PTD_STEP_FRAC};
    ahead_nns       = mst_narrow[`PTD_NNS_MSB:`PTD_NNS_LSB]
                      + {{(`PTD_NNS_W-`PTD_NS_W){1'b0}}, `PTD_STEP_NS}
                      + {{(`PTD_NNS_W-1){1'b0}}, ahead_nfrac_sum[`PTD_FRAC_W]};
  end

  assign mst_wide_ahead   = {ahead_sec, ahead_ns, ahead_frac_sum[`PTD_FRAC_W-1:0]};
  assign mst_narrow_ahead = {ahead_nns, ahead_nfrac_sum[`PTD_FRAC_W-1:0]};

  // a set request overrides an alignment in the same cycle
  assign slave_wide_src   = i_set_time ? i_set_wide_value : mst_wide_ahead;
  assign slave_narrow_src = i_set_time ? i_set_narrow_value : mst_narrow_ahead;

  // a separate wide and a separate narrow alignment per slave, one format each
  assign sync_pulse     = (state_reg == ST_ALIGN);
  assign tx_load_wide   = sync_pulse & i_wide_en & (mode_reg == `PTD_MODE_SHARED);
  assign tx_load_narrow = sync_pulse & i_narrow_en & (mode_reg == `PTD_MODE_SHARED);
  assign rx_load_wide   = (sync_pulse | i_set_time) & i_wide_en;
  assign rx_load_narrow = (sync_pulse | i_set_time) & i_narrow_en;

  // transmit slave is only aligned and used in the shared-master arrangement
  ptd_time_clock u_tx_slave (
    .i_sys_clk           (i_sys_clk),
    .i_rst_b             (i_rst_b),
    .i_period_rst_b      (i_tx_rst_b),
    .i_load_wide         (tx_load_wide | i_set_time),
    .i_wide_value        (slave_wide_src),
    .i_load_narrow       (tx_load_narrow | i_set_time),
    .i_narrow_value      (slave_narrow_src),
    .o_wide_time_value   (txs_wide),
    .o_narrow_time_value (txs_narrow)
  );

  // receive slave: period reset from the receive reset source
  ptd_time_clock u_rx_slave (
    .i_sys_clk           (i_sys_clk),
    .i_rst_b             (i_rst_b),
    .i_period_rst_b      (i_rx_rst_b),
    .i_load_wide         (rx_load_wide),
    .i_wide_value        (slave_wide_src),
    .i_load_narrow       (rx_load_narrow),
    .i_narrow_value      (slave_narrow_src),
    .o_wide_time_value   (rxs_wide),
    .o_narrow_time_value (rxs_narrow)
  );

  // single arrangement: master feeds transmit directly
  assign tx_wide_src   = (mode_reg == `PTD_MODE_SHARED) ? txs_wide : mst_wide;
  assign tx_narrow_src = (mode_reg == `PTD_MODE_SHARED) ? txs_narrow : mst_narrow;

  // periodic realignment; the slave reset stalls it so a held receive side is not loaded
  always @* begin
    state_next    = state_reg;
    sync_cnt_next = sync_cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (i_tx_rst_b && i_rx_rst_b) begin
          state_next    = ST_WAIT;
          sync_cnt_next = {`PTD_SYNC_CNT_W{1'b0}};
        end
      end
      ST_WAIT: begin
        if (!i_tx_rst_b || !i_rx_rst_b)
          state_next = ST_IDLE;
        else if (sync_cnt_reg == `PTD_SYNC_CYCLES)
          state_next = ST_ALIGN;
        else
          sync_cnt_next = sync_cnt_reg + {{(`PTD_SYNC_CNT_W-1){1'b0}}, 1'b1};
      end
      ST_ALIGN: begin
        sync_cnt_next = {`PTD_SYNC_CNT_W{1'b0}};
        state_next    = (i_tx_rst_b && i_rx_rst_b) ? ST_WAIT : ST_IDLE;
      end
      default: begin
        state_next    = ST_IDLE;
        sync_cnt_next = {`PTD_SYNC_CNT_W{1'b0}};
      end
    endcase
  end

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg    <= ST_IDLE;
      sync_cnt_reg <= {`PTD_SYNC_CNT_W{1'b0}};
      // starts at the receive clock's idle low level, so release shows no false edge
      rx_clk_d_reg <= 1'b0;
      mode_reg     <= `PTD_MODE_SINGLE;
      o_rx_aligned <= 1'b0;
    end else begin
      state_reg    <= state_next;
      sync_cnt_reg <= sync_cnt_next;
      rx_clk_d_reg <= i_rx_mac_clk;
      // mode only changes while the transmit side is held in period reset, so no half-aligned switch
      if (!i_tx_rst_b)
        mode_reg <= i_shared_master;
      if (state_reg == ST_IDLE)
        o_rx_aligned <= 1'b0;
      else if (sync_pulse)
        o_rx_aligned <= 1'b1;
    end
  end

  // transmit outputs refresh every cycle; unused format reads zero
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_transmit_wide_time_in   <= {`PTD_WIDE_W{1'b0}};
      o_transmit_narrow_time_in <= {`PTD_NARROW_W{1'b0}};
    end else begin
      o_transmit_wide_time_in   <= i_wide_en ? tx_wide_src : {`PTD_WIDE_W{1'b0}};
      o_transmit_narrow_time_in <= i_narrow_en ? tx_narrow_src : {`PTD_NARROW_W{1'b0}};
    end
  end

  // receive outputs refresh on each rising receive clock edge
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_receive_wide_time_in   <= {`PTD_WIDE_W{1'b0}};
      o_receive_narrow_time_in <= {`PTD_NARROW_W{1'b0}};
    end else if (rx_edge) begin
      o_receive_wide_time_in   <= i_wide_en ? rxs_wide : {`PTD_WIDE_W{1'b0}};
      o_receive_narrow_time_in <= i_narrow_en ? rxs_narrow : {`PTD_NARROW_W{1'b0}};
    end
  end

  // the shared reference clock for the pll and mac is board wiring and has no logic here

endmodule

// file: shared/ptd_defines.vh
// constants for the time-of-day supply that feeds a mac's timestamp inputs
// assumes a single 200 mhz system clock that is also the mac transmit clock
`ifndef PTD_DEFINES_VH
`define PTD_DEFINES_VH

`define PTD_WIDE_W        96
`define PTD_NARROW_W      64
`define PTD_SEC_W         48
`define PTD_NS_W          32
`define PTD_FRAC_W        16
`define PTD_NNS_W         48
`define PTD_SEC_MSB       95
`define PTD_SEC_LSB       48
`define PTD_NS_MSB        47
`define PTD_NS_LSB        16
`define PTD_FRAC_MSB      15
`define PTD_NNS_MSB       63
`define PTD_NNS_LSB       16
`define PTD_CLK_PERIOD_NS 5
`define PTD_NS_PER_SEC    32'h3b9aca00
`define PTD_STEP_NS       32'h00000005
`define PTD_STEP_FRAC     16'h0000
`define PTD_SYNC_CYCLES   8'h3f
`define PTD_SYNC_CNT_W    8
`define PTD_MODE_SINGLE   1'b0
`define PTD_MODE_SHARED   1'b1

`endif

// file: sim/ptd_asserts.sv
// port assertions for the time-of-day supply
// assumes one clock domain; bound to ptd_tod_supply below
`timescale 1ns/10ps
`include "ptd_defines.vh"
module ptd_asserts (
  input wire logic                     i_sys_clk,
  input wire logic                     i_rst_b,
  input wire logic                     i_tx_rst_b,
  input wire logic                     i_rx_rst_b,
  input wire logic                     i_rx_mac_clk,
  input wire logic                     i_wide_en,
  input wire logic                     i_narrow_en,
  input wire logic                     i_set_time,
  input wire logic [`PTD_WIDE_W-1:0]   i_set_wide_value,
  input wire logic [`PTD_WIDE_W-1:0]   o_transmit_wide_time_in,
  input wire logic [`PTD_NARROW_W-1:0] o_transmit_narrow_time_in,
  input wire logic [`PTD_NARROW_W-1:0] o_receive_narrow_time_in,
  input wire logic                     o_rx_aligned
);
  logic [7:0] run_reg;
  // counts cycles with both period resets high, saturating so it never wraps
  always_ff @(posedge i_sys_clk or negedge i_rst_b)
    if (!i_rst_b) run_reg <= 8'h00;
    else if (!(i_tx_rst_b && i_rx_rst_b)) run_reg <= 8'h00;
    else if (run_reg != 8'hff) run_reg <= run_reg + 8'h01;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_tx_run;
    (i_tx_rst_b && !i_set_time && i_wide_en && i_narrow_en)[*3];
  endsequence
  sequence s_load;
    (i_set_time && i_wide_en && i_tx_rst_b) ##1 (i_wide_en && i_tx_rst_b);
  endsequence
  a_wide_off_zero: assert property ((!i_wide_en)[*2] |-> o_transmit_wide_time_in == 96'h0)
    else $error("tx wide value not zero while disabled");
  a_narrow_off_zero: assert property ((!i_narrow_en)[*2] |-> o_transmit_narrow_time_in == 64'h0)
    else $error("tx narrow value not zero while disabled");
  a_tx_reset_zero: assert property ((!i_tx_rst_b)[*3] |-> o_transmit_narrow_time_in == 64'h0)
    else $error("tx value not zero in transmit reset");
  a_wide_ns_step: assert property (s_tx_run ##0 o_transmit_wide_time_in[47:16] < 32'h3b9ac9fb
    |=> o_transmit_wide_time_in[47:16] == $past(o_transmit_wide_time_in[47:16]) + 32'h5)
    else $error("tx wide ns did not step by 5");
  a_narrow_ns_step: assert property (s_tx_run
    |=> o_transmit_narrow_time_in[63:16] == $past(o_transmit_narrow_time_in[63:16]) + 48'h5)
    else $error("tx narrow ns did not step by 5");
  a_wide_set_load: assert property (s_load |=> o_transmit_wide_time_in == $past(i_set_wide_value, 2))
    else $error("tx wide value not loaded two cycles after set");
  a_idle_not_aligned: assert property ((!(i_tx_rst_b && i_rx_rst_b))[*3] |-> !o_rx_aligned)
    else $error("aligned flag high in period reset");
  a_align_in_time: assert property (run_reg >= 8'h50 |-> o_rx_aligned)
    else $error("alignment not reached in time");
  a_rx_value_hold: assert property ((i_rx_rst_b && i_narrow_en && !i_rx_mac_clk)[*4]
    |-> $stable(o_receive_narrow_time_in))
    else $error("rx value changed without rx clock edge");
endmodule
bind ptd_tod_supply ptd_asserts u_chk (.i_sys_clk, .i_rst_b, .i_tx_rst_b, .i_rx_rst_b, .i_rx_mac_clk,
  .i_wide_en, .i_narrow_en, .i_set_time, .i_set_wide_value, .o_transmit_wide_time_in,
  .o_transmit_narrow_time_in, .o_receive_narrow_time_in, .o_rx_aligned);

// file: sim/ptd_mac_model.sv
// mac stand-in: makes the receive clock and captures the transmit time
// assumes i_sys_clk is the mac transmit clock
`timescale 1ns/10ps
`include "ptd_defines.vh"
module ptd_mac_model #(
  parameter int RX_DIV = 3
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rx_stall,
  input  wire logic [`PTD_WIDE_W-1:0] i_tx_wide,
  output logic                        o_rx_mac_clk,
  output logic [`PTD_WIDE_W-1:0]      o_tx_stamp
);
  int div_reg = 0;
  initial o_rx_mac_clk = 1'b0;
  // a stalled mac holds its receive clock low: the slow case
  always @(posedge i_sys_clk) begin
    o_tx_stamp <= i_tx_wide;
    if (i_rx_stall) begin
      div_reg <= 0;
      o_rx_mac_clk <= 1'b0;
    end else if (div_reg == RX_DIV - 1) begin
      div_reg <= 0;
      o_rx_mac_clk <= ~o_rx_mac_clk;
    end else
      div_reg <= div_reg + 1;
  end
endmodule

// file: sim/ptd_tod_supply_tb.sv
// self-checking bench for the time-of-day supply
// assumes ptd_defines.vh on the include path and the mac model beside it
`timescale 1ns/10ps
`include "ptd_defines.vh"
module ptd_tod_supply_tb;
  typedef struct {logic we, ne; logic [95:0] wv, w1; logic [63:0] nv, n1;} ptd_row_t;
  logic clk = 1'b0, rst_b = 1'b0, tx_rst_b = 1'b0, rx_rst_b = 1'b0;
  logic we = 1'b1, ne = 1'b1, mode = 1'b0, set = 1'b0, stall = 1'b0;
  logic [95:0] set_w = 96'h0;
  logic [63:0] set_n = 64'h0, hold;
  wire rxc, al;
  wire [95:0] tx_wide, rx_wide, stamp;
  wire [63:0] tx_narrow, rx_narrow;
  int fails = 0, check_count = 0;
  // rows: wrap of ns at one second, exact boundary, disabled formats, fraction kept
  ptd_row_t rows [4] = '{
    '{1, 1, {48'h1, 32'h10, 16'h0}, {48'h1, 32'h15, 16'h0}, {48'h64, 16'h0}, {48'h69, 16'h0}},
    '{1, 1, {48'h7, 32'h3b9ac9fe, 16'h0}, {48'h8, 32'h3, 16'h0}, {48'hffff, 16'h0}, {48'h10004, 16'h0}},
    '{1, 0, {48'h0, 32'h3b9ac9fb, 16'h0}, {48'h1, 32'h0, 16'h0}, 64'h30000, 64'h0},
    '{0, 1, 96'h70000, 96'h0, {48'h0, 16'h8000}, {48'h5, 16'h8000}}};
  ptd_tod_supply uut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_tx_rst_b(tx_rst_b), .i_rx_rst_b(rx_rst_b),
    .i_rx_mac_clk(rxc), .i_wide_en(we), .i_narrow_en(ne), .i_shared_master(mode), .i_set_time(set),
    .i_set_wide_value(set_w), .i_set_narrow_value(set_n), .o_transmit_wide_time_in(tx_wide),
    .o_transmit_narrow_time_in(tx_narrow), .o_receive_wide_time_in(rx_wide),
    .o_receive_narrow_time_in(rx_narrow), .o_rx_aligned(al));
  ptd_mac_model #(.RX_DIV(3)) mac (.i_sys_clk(clk), .i_rx_stall(stall), .i_tx_wide(tx_wide),
    .o_rx_mac_clk(rxc), .o_tx_stamp(stamp));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_aligned;
    int n;
    for (n = 0; n < 300 && al !== 1'b1; n++) @(posedge clk);
    if (n == 300) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // rx may only lag tx by up to 50 ns, under two rx clock periods; a lead shows as a huge difference
  task automatic check_lag;
    logic [63:0] d;
    d = tx_narrow - rx_narrow;
    check("rx lag", 96'(d[63:16] <= 48'h32), 96'h1);
  endtask
  initial begin
    forever #2.5 clk = ~clk; // this one clock also stands for the shared pll and mac reference
  end
  initial begin
    repeat (10) @(posedge clk);
    check("tx wide in reset", tx_wide, 96'h0);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("tx narrow in tx reset", 96'(tx_narrow), 96'h0);
    check("aligned idle", 96'(al), 96'h0);
    @(posedge clk);
    tx_rst_b <= 1'b1;
    rx_rst_b <= 1'b1;
    wait_aligned();
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      we <= rows[i].we;
      ne <= rows[i].ne;
      set_w <= rows[i].wv;
      set_n <= rows[i].nv;
      set <= 1'b1;
      @(posedge clk);
      set <= 1'b0;
      @(posedge clk);
      #1;
      check("tx wide load", tx_wide, rows[i].we ? rows[i].wv : 96'h0);
      check("tx narrow load", 96'(tx_narrow), 96'(rows[i].ne ? rows[i].nv : 64'h0));
      @(posedge clk);
      #1;
      check("tx wide step", tx_wide, rows[i].w1);
      check("tx narrow step", 96'(tx_narrow), 96'(rows[i].n1));
      check("mac stamp", stamp, rows[i].we ? rows[i].wv : 96'h0);
      $display("test row %0d done", i);
    end
    @(posedge clk);
    stall <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    hold = rx_narrow;
    repeat (20) @(posedge clk);
    #1;
    check("rx hold", 96'(rx_narrow), 96'(hold));
    @(posedge clk);
    stall <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check_lag();
    check("rx wide off", rx_wide, 96'h0);
    $display("test rx hold done");
    @(posedge clk);
    mode <= 1'b1;
    we <= 1'b1;
    ne <= 1'b1;
    tx_rst_b <= 1'b0;
    rx_rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("aligned in reset", 96'(al), 96'h0);
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rx narrow in reset", 96'(rx_narrow), 96'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    // period resets stay low past the general reset so the shared mode is latched
    repeat (2) @(posedge clk);
    tx_rst_b <= 1'b1;
    rx_rst_b <= 1'b1;
    wait_aligned();
    repeat (10) @(posedge clk);
    #1;
    check_lag();
    check("rx wide lag", 96'((tx_wide[47:16] - rx_wide[47:16]) <= 32'h32 && rx_wide != 96'h0), 96'h1);
    $display("test shared master done");
    tally_and_finish();
  end
endmodule
